// >>> core/adc_ctrl_pkg.sv
// package for the converter compare and low-power control block
// assumes a 32-bit AXI4-Lite master and a SAR core on the same bus clock
`default_nettype none
package adc_ctrl_pkg;
  // register byte addresses, one aligned word each
  localparam logic [7:0] OFF_CFG = 8'h00; // converter_configuration
  localparam logic [7:0] OFF_TRIG = 8'h04; // trigger_compare_control
  localparam logic [7:0] OFF_CHAN = 8'h08; // channel_irq_control
  localparam logic [7:0] OFF_RES_HI = 8'h0C; // result_high_byte
  localparam logic [7:0] OFF_RES_LO = 8'h10; // result_low_byte
  localparam logic [7:0] OFF_CMP_HI = 8'h14; // compare_value_high
  localparam logic [7:0] OFF_CMP_LO = 8'h18; // compare_value_low

  // field positions
  localparam int CFG_LOW_POWER = 7;
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_LONG_SAMPLE = 4;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_CLK_LSB = 0;
  localparam int TRIG_ACTIVE = 7;
  localparam int TRIG_HW = 6;
  localparam int TRIG_CMP_EN = 5;
  localparam int TRIG_CMP_GT = 4;
  localparam int CHAN_DONE = 7;
  localparam int CHAN_IRQ_EN = 6;
  localparam int CHAN_CONT = 5;

  // encodings
  localparam logic [1:0] MODE_10BIT = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;
  localparam logic [4:0] CHAN_OFF = 5'h1F;

  // values after reset
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] TRIG_RESET = 8'h00;
  localparam logic [4:0] CHAN_SEL_RESET = 5'h1F;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } conv_state_e;

  // request to the SAR core
  typedef struct packed {
    logic start; // one-cycle pulse, begin a conversion
    logic abort; // one-cycle pulse, drop the running conversion
    logic [4:0] channel;
    logic [1:0] clk_sel;
    logic [1:0] divider;
    logic long_sample;
    logic low_power;
    logic res10; // 10-bit resolution when high
  } sar_req_s;

  // answer from the SAR core
  typedef struct packed {
    logic done; // one-cycle pulse, conversion finished
    logic [9:0] data; // raw result, 8-bit results in bits 7:0
  } sar_rsp_s;
endpackage
`default_nettype wire

// >>> core/adc_compare_lowpower_ctrl.sv
// register file, compare path and low-power sequencing of the converter
// assumes an AXI4-Lite master on aclk, a SAR core answering on aclk,
// and low-power mode levels from the system controller on aclk
//
// Functional notes
// - limit check runs only while compare enable is set
// - upper limit: done flag only when result is at least compare value
// - lower limit: done flag only when result is below compare value
// - done flag set with irq enable raises the interrupt request
// - compare stores result minus compare value, sign bit dropped
// - sign of stored difference follows the limit direction, not stored
// - failed compare does not set done flag and leaves result unchanged
// - entering wait lets a running conversion finish
// - in wait, hardware trigger and continuous mode still start conversions
// - bus, halved bus and async clock stay selectable during wait
// - completion in wait sets done flag and wakes via interrupt
// - stop3 without async clock aborts to idle, result kept
// - stop3 with async clock keeps converting and starting
// - completion in stop3 sets done flag and wakes via interrupt
// - stop2 disables converter; registers return to reset values
// - configuration register fields: low power, divider, sample, mode, clock
// - trigger register fields: active, hw trigger, compare enable, greater
// - channel register fields: done flag, irq enable, continuous, channel
// - 10-bit result held between high and low reads blocks new transfer
// - blocked single failed compare stops; other blocked cases restart
`default_nettype none
module adc_compare_lowpower_ctrl (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic hw_trigger, // hardware trigger pin, asynchronous
  input wire logic wait_mode, // processor in wait
  input wire logic stop3_mode, // processor in stop3
  input wire logic stop2_mode, // processor in stop2
  output adc_ctrl_pkg::sar_req_s sar_req, // control to the SAR core
  input wire adc_ctrl_pkg::sar_rsp_s sar_rsp, // answer from the SAR core
  output logic irq // converter interrupt request, level
);

  typedef struct packed {
    adc_ctrl_pkg::conv_state_e st;
    logic [7:0] cfg;
    logic [2:0] trig; // hw trigger, compare enable, compare greater
    logic done_flag;
    logic irq_en;
    logic cont;
    logic [4:0] chan;
    logic [1:0] cmp_hi;
    logic [7:0] cmp_lo;
    logic [9:0] result;
    logic hi_read; // high byte read, low byte still pending
    logic trg_s1;
    logic trg_s2;
    logic trg_d;
    logic start;
    logic abort;
    logic irq;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [7:0] w_byte;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ctrl_state_s;

  localparam ctrl_state_s STATE_RESET = '{
    st: adc_ctrl_pkg::ST_IDLE,
    cfg: adc_ctrl_pkg::CFG_RESET,
    trig: 3'h0,
    chan: adc_ctrl_pkg::CHAN_SEL_RESET,
    default: '0
  };

  ctrl_state_s s_reg;
  ctrl_state_s s_next;

  // every assertion in this module runs on aclk and sleeps through reset
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // true when the conversion result meets the selected limit
  function automatic logic limit_met(input logic [9:0] res, input logic [9:0] cmp,
                                     input logic greater);
    if (greater)
      limit_met = (res >= cmp);
    else
      limit_met = (res < cmp);
  endfunction

  // decoded views of the registered controls
  logic mode10;
  logic cmp_en;
  logic cmp_gt;
  logic async_sel;
  logic stop3_halt;
  logic [9:0] raw;
  logic [9:0] cmp_val;
  logic [10:0] diff;
  logic cond;
  logic passes;
  logic wr_fire;
  logic ar_fire;
  logic rd_low;
  logic blocked;
  logic done_evt;

  assign mode10 = (s_reg.cfg[adc_ctrl_pkg::CFG_MODE_LSB +: 2] == adc_ctrl_pkg::MODE_10BIT);
  assign cmp_en = s_reg.trig[1];
  assign cmp_gt = s_reg.trig[0];
  assign async_sel = (s_reg.cfg[adc_ctrl_pkg::CFG_CLK_LSB +: 2] == adc_ctrl_pkg::CLK_ASYNC);
  assign stop3_halt = stop3_mode && !async_sel;
  // 8-bit mode narrows both operands so the same subtract serves both widths
  assign raw = mode10 ? sar_rsp.data : {2'h0, sar_rsp.data[7:0]};
  assign cmp_val = mode10 ? {s_reg.cmp_hi, s_reg.cmp_lo} : {2'h0, s_reg.cmp_lo};
  // one bit wider than the operands; the sign bit is never stored
  assign diff = {1'b0, raw} - {1'b0, cmp_val};
  assign cond = limit_met(raw, cmp_val, cmp_gt);
  assign passes = !cmp_en || cond;
  assign wr_fire = s_reg.aw_full && s_reg.w_full;
  assign ar_fire = arvalid && s_reg.arready;
  assign rd_low = ar_fire && (araddr == adc_ctrl_pkg::OFF_RES_LO);
  assign blocked = mode10 && s_reg.hi_read && !rd_low;
  // a write, stop2 or stop3 on a synchronous clock in the same cycle invalidates the result
  assign done_evt = (s_reg.st == adc_ctrl_pkg::ST_CONV) && sar_rsp.done && !wr_fire
                    && !stop2_mode && !stop3_halt;

  // next-state logic for bus slave, registers and conversion sequencing
  always_comb
  begin
    s_next = s_reg;
    s_next.start = 1'b0;
    s_next.abort = 1'b0;
    // hardware trigger passes two flops before the edge detector
    s_next.trg_s1 = hw_trigger;
    s_next.trg_s2 = s_reg.trg_s1;
    s_next.trg_d = s_reg.trg_s2;

    // address and data channels are taken independently
    if (awvalid && s_reg.awready)
    begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = awaddr;
    end
    if (wvalid && s_reg.wready)
    begin
      s_next.w_full = 1'b1;
      s_next.w_byte = wdata[7:0];
      s_next.w_lane0 = wstrb[0];
    end
    if (s_reg.bvalid && bready)
      s_next.bvalid = 1'b0;

    // register write; a write to a control register with byte lane 0 enabled aborts the conversion
    if (wr_fire)
    begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = adc_ctrl_pkg::RESP_OKAY;
      case (s_reg.aw_addr)
        adc_ctrl_pkg::OFF_CFG,
        adc_ctrl_pkg::OFF_TRIG,
        adc_ctrl_pkg::OFF_CHAN,
        adc_ctrl_pkg::OFF_CMP_HI,
        adc_ctrl_pkg::OFF_CMP_LO:
        begin
          if (s_reg.w_lane0)
          begin
            s_next.abort = (s_reg.st == adc_ctrl_pkg::ST_CONV);
            s_next.st = adc_ctrl_pkg::ST_IDLE;
          end
        end
        adc_ctrl_pkg::OFF_RES_HI,
        adc_ctrl_pkg::OFF_RES_LO:
          s_next.bresp = adc_ctrl_pkg::RESP_OKAY; // read-only, write ignored
        default:
          s_next.bresp = adc_ctrl_pkg::RESP_SLVERR;
      endcase
      if (s_reg.w_lane0)
      begin
        case (s_reg.aw_addr)
          adc_ctrl_pkg::OFF_CFG:
            s_next.cfg = s_reg.w_byte;
          adc_ctrl_pkg::OFF_TRIG:
            s_next.trig = s_reg.w_byte[adc_ctrl_pkg::TRIG_CMP_GT +: 3];
          adc_ctrl_pkg::OFF_CHAN:
          begin
            s_next.irq_en = s_reg.w_byte[adc_ctrl_pkg::CHAN_IRQ_EN];
            s_next.cont = s_reg.w_byte[adc_ctrl_pkg::CHAN_CONT];
            s_next.chan = s_reg.w_byte[4:0];
            s_next.done_flag = 1'b0;
            // software trigger unless hardware trigger selected or channel off
            if (!s_reg.trig[2] && s_reg.w_byte[4:0] != adc_ctrl_pkg::CHAN_OFF)
            begin
              s_next.start = 1'b1;
              s_next.st = adc_ctrl_pkg::ST_CONV;
            end
          end
          adc_ctrl_pkg::OFF_CMP_HI:
            s_next.cmp_hi = s_reg.w_byte[1:0];
          adc_ctrl_pkg::OFF_CMP_LO:
            s_next.cmp_lo = s_reg.w_byte;
          default:
            s_next.cmp_lo = s_reg.cmp_lo;
        endcase
      end
    end

    // register read; result bytes carry the high-then-low interlock
    if (s_reg.rvalid && rready)
      s_next.rvalid = 1'b0;
    if (ar_fire)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp = adc_ctrl_pkg::RESP_OKAY;
      s_next.rdata = 32'h0000_0000;
      case (araddr)
        adc_ctrl_pkg::OFF_CFG:
          s_next.rdata[7:0] = s_reg.cfg;
        adc_ctrl_pkg::OFF_TRIG:
          s_next.rdata[7:0] = {s_reg.st == adc_ctrl_pkg::ST_CONV, s_reg.trig, 4'h0};
        adc_ctrl_pkg::OFF_CHAN:
          s_next.rdata[7:0] = {s_reg.done_flag, s_reg.irq_en, s_reg.cont, s_reg.chan};
        adc_ctrl_pkg::OFF_RES_HI:
        begin
          s_next.rdata[1:0] = mode10 ? s_reg.result[9:8] : 2'h0;
          s_next.hi_read = mode10;
        end
        adc_ctrl_pkg::OFF_RES_LO:
        begin
          s_next.rdata[7:0] = s_reg.result[7:0];
          s_next.hi_read = 1'b0;
          s_next.done_flag = 1'b0;
        end
        adc_ctrl_pkg::OFF_CMP_HI:
          s_next.rdata[1:0] = s_reg.cmp_hi;
        adc_ctrl_pkg::OFF_CMP_LO:
          s_next.rdata[7:0] = s_reg.cmp_lo;
        default:
          s_next.rresp = adc_ctrl_pkg::RESP_SLVERR;
      endcase
    end

    // hardware trigger edge starts from idle, ignored mid-conversion
    if (s_reg.trig[2] && s_reg.trg_s2 && !s_reg.trg_d && !wr_fire && !stop3_halt
        && s_reg.st == adc_ctrl_pkg::ST_IDLE && s_reg.chan != adc_ctrl_pkg::CHAN_OFF)
    begin
      s_next.start = 1'b1;
      s_next.st = adc_ctrl_pkg::ST_CONV;
    end

    // conversion end; done handled after the read so a set wins the clear
    if (done_evt)
    begin
      if (passes && !blocked)
      begin
        s_next.result = cmp_en ? (mode10 ? diff[9:0] : {2'h0, diff[7:0]}) : raw;
        s_next.done_flag = 1'b1;
        s_next.start = s_reg.cont;
        s_next.st = s_reg.cont ? adc_ctrl_pkg::ST_CONV : adc_ctrl_pkg::ST_IDLE;
      end
      else if (cmp_en && !cond && !s_reg.cont)
        s_next.st = adc_ctrl_pkg::ST_IDLE;
      else
      begin
        // blocked passing result, or failed compare in continuous mode: convert again
        s_next.start = 1'b1;
        s_next.st = adc_ctrl_pkg::ST_CONV;
      end
    end

    // stop3 on a synchronous clock: abort, go idle, keep result
    if (stop3_halt)
    begin
      s_next.abort = (s_reg.st == adc_ctrl_pkg::ST_CONV);
      s_next.start = 1'b0;
      s_next.st = adc_ctrl_pkg::ST_IDLE;
    end

    // stop2 returns every converter register to its reset value
    if (stop2_mode)
    begin
      s_next.st = adc_ctrl_pkg::ST_IDLE;
      s_next.cfg = adc_ctrl_pkg::CFG_RESET;
      s_next.trig = 3'h0;
      s_next.done_flag = 1'b0;
      s_next.irq_en = 1'b0;
      s_next.cont = 1'b0;
      s_next.chan = adc_ctrl_pkg::CHAN_SEL_RESET;
      s_next.cmp_hi = 2'h0;
      s_next.cmp_lo = 8'h00;
      s_next.result = 10'h000;
      s_next.hi_read = 1'b0;
      s_next.start = 1'b0;
      s_next.abort = (s_reg.st == adc_ctrl_pkg::ST_CONV);
    end

    // interrupt is a level while the flag and its enable stand
    s_next.irq = s_next.done_flag && s_next.irq_en;
    s_next.awready = !s_next.aw_full && !s_next.bvalid;
    s_next.wready = !s_next.w_full && !s_next.bvalid;
    s_next.arready = !s_next.rvalid;
  end

  // single state register, synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_reg <= STATE_RESET;
    else
      s_reg <= s_next;
  end

  // outputs straight from the state register
  assign awready = s_reg.awready;
  assign wready = s_reg.wready;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = s_reg.arready;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign irq = s_reg.irq;
  // clock select stays live in wait; the SAR core picks the source
  assign sar_req.clk_sel = s_reg.cfg[adc_ctrl_pkg::CFG_CLK_LSB +: 2];
  assign sar_req.divider = s_reg.cfg[adc_ctrl_pkg::CFG_DIV_LSB +: 2];
  assign sar_req.long_sample = s_reg.cfg[adc_ctrl_pkg::CFG_LONG_SAMPLE];
  assign sar_req.low_power = s_reg.cfg[adc_ctrl_pkg::CFG_LOW_POWER];
  assign sar_req.res10 = mode10;
  assign sar_req.channel = s_reg.chan;
  assign sar_req.start = s_reg.start;
  assign sar_req.abort = s_reg.abort;

  done_sets_flag_a: assert property (done_evt && passes && !blocked |=> s_reg.done_flag)
    else $error("passing conversion did not set done flag");
  cmp_false_hold_a: assert property (done_evt && cmp_en && !cond |=> $stable(s_reg.result))
    else $error("failed compare changed the result");
  blocked_restart_a: assert property (done_evt && passes && blocked
    |=> s_reg.start && s_reg.st == adc_ctrl_pkg::ST_CONV && $stable(s_reg.result))
    else $error("blocked transfer did not restart");
  single_stop_a: assert property (done_evt && cmp_en && !cond && !s_reg.cont
    |=> s_reg.st == adc_ctrl_pkg::ST_IDLE && !s_reg.start)
    else $error("single failed compare did not stop");
  diff_store_a: assert property (done_evt && cmp_en && cond && !blocked && mode10
    |=> s_reg.result == 10'($past(raw) - $past(cmp_val)))
    else $error("stored difference wrong");
  stop3_abort_a: assert property (stop3_halt && s_reg.st == adc_ctrl_pkg::ST_CONV
    && !stop2_mode
    |=> s_reg.st == adc_ctrl_pkg::ST_IDLE && s_reg.abort && $stable(s_reg.result))
    else $error("stop3 did not abort to idle");
  stop2_clear_a: assert property (stop2_mode |=> s_reg.cfg == adc_ctrl_pkg::CFG_RESET
    && s_reg.result == 10'h000 && !s_reg.done_flag && !irq)
    else $error("stop2 left registers set");
  irq_raise_a: assert property (done_evt && passes && !blocked && s_reg.irq_en
    |=> irq)
    else $error("interrupt missing on done flag");
  wait_continue_a: assert property (wait_mode && s_reg.st == adc_ctrl_pkg::ST_CONV
    && !sar_rsp.done && !wr_fire && !stop3_halt && !stop2_mode
    |=> s_reg.st == adc_ctrl_pkg::ST_CONV)
    else $error("wait aborted a conversion");
  raw_store_a: assert property (done_evt && !cmp_en && !blocked
    |=> s_reg.result == $past(raw))
    else $error("raw result not stored");

endmodule // adc_compare_lowpower_ctrl
`default_nettype wire

// >>> test/adc_compare_lowpower_ctrl_tb_top.sv
// self-checking bench for the converter compare and low-power control block
// assumes the block alone on one 50 MHz clock; the bench is the AXI4-Lite
// master, the SAR core and the system power controller at once
`default_nettype none
module adc_compare_lowpower_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'h0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'h0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'h0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'h0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'h0;
  logic hw_trigger = 1'h0;
  logic wait_mode = 1'h0;
  logic stop3_mode = 1'h0;
  logic stop2_mode = 1'h0;
  adc_ctrl_pkg::sar_req_s sar_req;
  adc_ctrl_pkg::sar_rsp_s sar_rsp = '0;
  logic irq;
  int failures = 0;
  int check_count = 0;
  int starts = 0;
  int aborts = 0;
  logic [31:0] seed = 32'h3AF0EB11;
  logic [9:0] exp_res = 10'h000;

  adc_compare_lowpower_ctrl DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .hw_trigger(hw_trigger),
    .wait_mode(wait_mode), .stop3_mode(stop3_mode), .stop2_mode(stop2_mode),
    .sar_req(sar_req), .sar_rsp(sar_rsp), .irq(irq)
  );

  always #10 aclk = ~aclk;

  // count start and abort pulses here, since a pulse can coincide with bvalid
  always @(posedge aclk)
  begin
    if (sar_req.start === 1'h1)
      starts <= starts + 1;
    if (sar_req.abort === 1'h1)
      aborts <= aborts + 1;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // a clock edge passes first so no handshake signal is driven twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er = adc_ctrl_pkg::RESP_OKAY);
    int n;
    begin
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= 4'hF;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do
      begin
        @(posedge aclk);
        n++;
        if (awready === 1'h1)
          awvalid <= 1'h0;
        if (wready === 1'h1)
          wvalid <= 1'h0;
      end while (bvalid !== 1'h1 && n < 100);
      bready <= 1'h0;
      chk("bvalid", 32'h1, {31'h0, bvalid});
      chk("bresp", {30'h0, er}, {30'h0, bresp});
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    begin
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do
      begin
        @(posedge aclk);
        n++;
        if (arready === 1'h1)
          arvalid <= 1'h0;
      end while (rvalid !== 1'h1 && n < 100);
      d = rdata;
      r = rresp;
      rready <= 1'h0;
      chk("rvalid", 32'h1, {31'h0, rvalid});
    end
  endtask

  task automatic cr(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    begin
      rd(a, d, r);
      chk(what, exp, d);
    end
  endtask

  // bounded wait for one more pulse on a counter
  task automatic wait_more(input string what, ref int cnt, input int base);
    int n;
    begin
      n = 0;
      while (cnt == base && n < 20)
      begin
        @(posedge aclk);
        n++;
      end
      chk(what, base + 1, cnt);
    end
  endtask

  // SAR completion: done stands for exactly one cycle
  task automatic pulse(input logic [9:0] d);
    sar_rsp <= {1'h1, d};
    @(posedge aclk);
    sar_rsp <= {1'h0, d};
  endtask

  task automatic results();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog, far beyond the thousand or so cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge aclk);
    failures++;
    results();
  end

  initial
  begin : main
    logic [31:0] r;
    logic [1:0] rs;
    logic [7:0] cfg;
    logic [7:0] cw;
    logic [9:0] cv;
    logic [9:0] dat;
    logic [9:0] mask;
    logic en;
    logic gt;
    logic ie;
    logic ok;
    int s0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    // reset values, reserved and read-only bits, unmapped places
    cr("cfg rst", adc_ctrl_pkg::OFF_CFG, 32'h00);
    cr("trig rst", adc_ctrl_pkg::OFF_TRIG, 32'h00);
    cr("chan rst", adc_ctrl_pkg::OFF_CHAN, 32'h1F);
    rd(8'h1C, r, rs);
    chk("unmapped", {30'h0, adc_ctrl_pkg::RESP_SLVERR}, {30'h0, rs});
    wr(8'h20, 8'h55, adc_ctrl_pkg::RESP_SLVERR);
    wr(adc_ctrl_pkg::OFF_TRIG, 8'hFC);
    cr("trig ro", adc_ctrl_pkg::OFF_TRIG, 32'h70);
    wr(adc_ctrl_pkg::OFF_CHAN, 8'hFF);
    cr("chan ro", adc_ctrl_pkg::OFF_CHAN, 32'h7F);
    // random limits, both directions, both resolutions; first two hit the boundary
    for (int i = 0; i < 24; i++)
    begin
      seed = xs(seed);
      cfg = {seed[7:4], (i % 3 == 2) ? 2'h1 : adc_ctrl_pkg::MODE_10BIT, 1'h0, seed[8]};
      mask = (i % 3 == 2) ? 10'h0FF : 10'h3FF;
      cv = seed[19:10] & mask;
      dat = (i < 2) ? cv : (seed[29:20] & mask);
      en = (i < 2) | seed[30];
      gt = (i < 2) ? ~i[0] : seed[31];
      ie = seed[0];
      wr(adc_ctrl_pkg::OFF_CFG, cfg);
      wr(adc_ctrl_pkg::OFF_CMP_HI, {6'h00, cv[9:8]});
      wr(adc_ctrl_pkg::OFF_CMP_LO, cv[7:0]);
      wr(adc_ctrl_pkg::OFF_TRIG, {2'h0, en, gt, 4'h0});
      s0 = starts;
      wr(adc_ctrl_pkg::OFF_CHAN, {1'h0, ie, 6'h03});
      wait_more("start", starts, s0);
      chk("res10", {31'h0, i % 3 != 2}, {31'h0, sar_req.res10});
      chk("chan out", 32'h3, {27'h0, sar_req.channel});
      pulse(dat);
      @(posedge aclk);
      ok = !en || (gt ? dat >= cv : dat < cv);
      if (ok)
        exp_res = en ? ((dat - cv) & mask) : dat;
      chk("irq", {31'h0, ok & ie}, {31'h0, irq});
      cr("done", adc_ctrl_pkg::OFF_CHAN, {24'h0, ok, ie, 6'h03});
      cr("stop", adc_ctrl_pkg::OFF_TRIG, {26'h0, en, gt, 4'h0});
      // in 8-bit mode the high byte reads zero even over an older 10-bit result
      cr("res hi", adc_ctrl_pkg::OFF_RES_HI, {30'h0, exp_res[9:8] & mask[9:8]});
      cr("res lo", adc_ctrl_pkg::OFF_RES_LO, {24'h0, exp_res[7:0]});
    end
    // high byte read, then a completion: transfer blocked, conversion restarted
    wr(adc_ctrl_pkg::OFF_CFG, 8'h08);
    wr(adc_ctrl_pkg::OFF_TRIG, 8'h00);
    s0 = starts;
    wr(adc_ctrl_pkg::OFF_CHAN, 8'h41);
    wait_more("start", starts, s0);
    rd(adc_ctrl_pkg::OFF_RES_HI, r, rs);
    s0 = starts;
    pulse(10'h155);
    wait_more("restart", starts, s0);
    chk("irq blk", 32'h0, {31'h0, irq});
    cr("lo blk", adc_ctrl_pkg::OFF_RES_LO, {24'h0, exp_res[7:0]});
    pulse(10'h2AA);
    exp_res = 10'h2AA;
    cr("done blk", adc_ctrl_pkg::OFF_CHAN, 32'hC1);
    cr("hi blk", adc_ctrl_pkg::OFF_RES_HI, 32'h2);
    cr("lo new", adc_ctrl_pkg::OFF_RES_LO, 32'hAA);
    // wait with continuous, stop3 on the async clock, stop3 on the bus clock
    for (int m = 0; m < 3; m++)
    begin
      seed = xs(seed);
      cfg = (m == 1) ? 8'h0B : ((m == 0) ? 8'h09 : 8'h08);
      cw = (m == 0) ? 8'h64 : 8'h44;
      wr(adc_ctrl_pkg::OFF_CFG, cfg);
      wr(adc_ctrl_pkg::OFF_TRIG, 8'h40);
      wr(adc_ctrl_pkg::OFF_CHAN, cw);
      s0 = starts;
      stop3_mode <= (m == 1);
      hw_trigger <= 1'h1;
      wait_more("hw start", starts, s0);
      hw_trigger <= 1'h0;
      wait_mode <= (m == 0);
      if (m == 2)
      begin
        s0 = aborts;
        stop3_mode <= 1'h1;
        wait_more("abort", aborts, s0);
        cr("idle", adc_ctrl_pkg::OFF_TRIG, 32'h40);
        pulse(10'h3C3);
      end
      else
      begin
        dat = seed[9:0];
        s0 = starts;
        pulse(dat);
        exp_res = dat;
        @(posedge aclk);
        chk("wake irq", 32'h1, {31'h0, irq});
        chk("clk sel", {30'h0, cfg[1:0]}, {30'h0, sar_req.clk_sel});
        if (m == 0)
          wait_more("cont", starts, s0);
      end
      cr("lp done", adc_ctrl_pkg::OFF_CHAN, {24'h0, m != 2, cw[6:0]});
      cr("lp hi", adc_ctrl_pkg::OFF_RES_HI, {30'h0, exp_res[9:8]});
      // the low read clears the interlock before the next pass enters stop3
      cr("lp lo", adc_ctrl_pkg::OFF_RES_LO, {24'h0, exp_res[7:0]});
      wait_mode <= 1'h0;
      stop3_mode <= 1'h0;
    end
    // configuration fields, then stop2 puts every register back to reset
    wr(adc_ctrl_pkg::OFF_CFG, 8'h98);
    cr("cfg rw", adc_ctrl_pkg::OFF_CFG, 32'h98);
    chk("cfg out", 32'h13, {27'h0, sar_req.low_power, sar_req.divider,
        sar_req.long_sample, sar_req.res10});
    wr(adc_ctrl_pkg::OFF_TRIG, 8'h30);
    wr(adc_ctrl_pkg::OFF_CHAN, 8'h5F);
    stop2_mode <= 1'h1;
    repeat (4) @(posedge aclk);
    stop2_mode <= 1'h0;
    cr("cfg s2", adc_ctrl_pkg::OFF_CFG, 32'h00);
    cr("trig s2", adc_ctrl_pkg::OFF_TRIG, 32'h00);
    cr("chan s2", adc_ctrl_pkg::OFF_CHAN, 32'h1F);
    cr("res s2", adc_ctrl_pkg::OFF_RES_LO, 32'h00);
    // after stop2 software sets the converter up again before it converts
    wr(adc_ctrl_pkg::OFF_CFG, 8'h08);
    wr(adc_ctrl_pkg::OFF_TRIG, 8'h00);
    s0 = starts;
    wr(adc_ctrl_pkg::OFF_CHAN, 8'h41);
    wait_more("s2 start", starts, s0);
    results();
  end
endmodule // adc_compare_lowpower_ctrl_tb_top
`default_nettype wire
